// ### hdl/bit_pkg.sv
// What this block does
// R1: In master mode a mode command of the data-carrying class sends the mode data register as the word right after the command word.
// R2: The master processor loads the mode data register before such a mode command is started.
// R3: In remote mode nothing depends on the mode data register contents.
// R4: Each transfer loads the data area pointer register with the start of the data area, used for the tag word. Here it is only written over APB at OFS_PTR.
// R5: The data address register starts at the pointer plus one, past the tag word.
// R6: The data address register steps by one after each data word fetched or stored.
// R7: The word count register is loaded from the word count of the bus command.
// R8: The word count register drops by one for each data word transferred.
// R9: A set program interrupt flag in instruction word one sets the matching interrupt status flag.
// R10: Status fields are scanned from the rightmost and the first non-zero field gives the interrupt level.
// R11: The data phase ends when the word count reaches zero, with no further memory access.
`default_nettype none
package bit_pkg;
    // ==================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_MODEDAT = 8'h04;
    localparam logic [7:0] OFS_PTR     = 8'h08;
    localparam logic [7:0] OFS_CMD     = 8'h0C;
    localparam logic [7:0] OFS_IWORD1  = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_ISR     = 8'h18;
    localparam logic [7:0] OFS_IMASK   = 8'h1C;
    localparam logic [7:0] OFS_DADDR   = 8'h20;
    localparam logic [7:0] OFS_WCOUNT  = 8'h24;
    localparam logic [7:0] OFS_LEVEL   = 8'h28;
    // ==================================================
    // Field positions
    localparam int CTRL_MASTER_BIT = 0;
    localparam int CTRL_START_BIT  = 1;
    localparam int CTRL_MODECMD_BIT = 2;
    localparam int IW1_PCI_BIT     = 15;
    localparam int ISR_PCI_BIT     = 0;
    localparam int ISR_DONE_BIT    = 1;
    localparam int ISR_MODE_BIT    = 2;
    localparam int ISR_FIELDS      = 8;
    localparam int ISR_FIELD_W     = 4;
    localparam int LEVEL_W         = 4;
    // ==================================================
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [5:0]  RST_CNT  = 6'h00;
    localparam logic [3:0]  LEVEL_NONE = 4'hF;

    typedef enum {ST_IDLE, ST_MODEW, ST_ADDR, ST_XFER, ST_WAIT}
        bit_state_type;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bit_mem_req_type;
endpackage
`default_nettype wire

// ### hdl/bit_bus_interface_unit.sv
`default_nettype none
module bit_bus_interface_unit
    import bit_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Memory port
    output bit_mem_req_type  mem_req_out,
    input  wire logic        mem_ack_in,
    input  wire logic [15:0] mem_rdata_in,
    // Serial bus word port
    output logic             tx_valid_out,
    output logic      [15:0] tx_word_out,
    input  wire logic        tx_ready_in,
    input  wire logic        rx_valid_in,
    input  wire logic [15:0] rx_word_in,
    // Interrupts
    output logic             irq_out,
    output logic      [LEVEL_W-1:0] level_out
);
    // ==================================================
    // Register state
    logic [2:0]  ctrl_ff;
    logic [15:0] mode_data_reg_ff;
    logic [15:0] data_area_pointer_reg_ff;
    logic [5:0]  cmd_count_ff;
    logic [15:0] instruction_word_one_reg_ff;
    logic [ISR_FIELDS*ISR_FIELD_W-1:0] interrupt_status_reg_ff;
    logic [ISR_FIELDS*ISR_FIELD_W-1:0] imask_ff;
    logic [15:0] data_address_reg_ff;
    logic [5:0]  word_count_reg_ff;
    bit_state_type state_ff;
    logic        start_pls;
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] nxt_rdata;
    logic        hit;
    logic        done_evt;
    logic        mode_evt;
    logic        word_evt;
    logic [31:0] isr_set;

    // APB phase decode and start pulse
    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign rd_acc = psel_in & ~penable_in & ~pwrite_in;
    assign start_pls = wr_acc && paddr_in == OFS_CTRL
                       && pwdata_in[CTRL_START_BIT];

    // ==================================================
    // Write decode
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff <= 3'h0;
            mode_data_reg_ff <= RST_HALF;
            data_area_pointer_reg_ff <= RST_HALF;
            cmd_count_ff <= RST_CNT;
            instruction_word_one_reg_ff <= RST_HALF;
            imask_ff <= RST_WORD;
        end else if (wr_acc) begin
            case (paddr_in)
                OFS_CTRL: begin
                    ctrl_ff[CTRL_MASTER_BIT] <= pwdata_in[CTRL_MASTER_BIT];
                    ctrl_ff[CTRL_MODECMD_BIT] <=
                        pwdata_in[CTRL_MODECMD_BIT];
                end
                OFS_MODEDAT: mode_data_reg_ff <= pwdata_in[15:0]; // [R2]
                OFS_PTR:     data_area_pointer_reg_ff <= pwdata_in[15:0];
                OFS_CMD:     cmd_count_ff <= pwdata_in[5:0];
                OFS_IWORD1:  instruction_word_one_reg_ff <= pwdata_in[15:0];
                OFS_IMASK:   imask_ff <= pwdata_in;
                default: ;
            endcase
        end
    end

    // ==================================================
    // APB read and answer, one wait-free access phase
    always_comb begin
        hit = 1'b1;
        case (paddr_in)
            OFS_CTRL:    nxt_rdata = {29'h0, ctrl_ff};
            OFS_MODEDAT: nxt_rdata = {16'h0, mode_data_reg_ff};
            OFS_PTR:     nxt_rdata = {16'h0, data_area_pointer_reg_ff};
            OFS_CMD:     nxt_rdata = {26'h0, cmd_count_ff};
            OFS_IWORD1:  nxt_rdata = {16'h0, instruction_word_one_reg_ff};
            OFS_STATUS:  nxt_rdata = {31'h0, state_ff != ST_IDLE};
            OFS_ISR:     nxt_rdata = interrupt_status_reg_ff;
            OFS_IMASK:   nxt_rdata = imask_ff;
            OFS_DADDR:   nxt_rdata = {16'h0, data_address_reg_ff};
            OFS_WCOUNT:  nxt_rdata = {26'h0, word_count_reg_ff};
            OFS_LEVEL:   nxt_rdata = {28'h0, level_out};
            default: begin
                nxt_rdata = RST_WORD;
                hit = 1'b0;
            end
        endcase
    end

    // Registered answer, ready in the first access cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= RST_WORD;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~hit;
            if (rd_acc) begin
                prdata_out <= nxt_rdata;
            end
        end
    end

    // ==================================================
    // Transfer sequencer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= ST_IDLE;
            data_address_reg_ff <= RST_HALF;
            word_count_reg_ff <= RST_CNT;
            mem_req_out <= '0;
            tx_valid_out <= 1'b0;
            tx_word_out <= RST_HALF;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_pls) begin
                        word_count_reg_ff <= cmd_count_ff; // [R7]
                        // Mode data only goes out as bus master
                        // Control register still holds the old word here
                        if (pwdata_in[CTRL_MASTER_BIT]
                            && pwdata_in[CTRL_MODECMD_BIT]) begin // [R3]
                            tx_valid_out <= 1'b1;
                            tx_word_out <= mode_data_reg_ff; // [R1]
                            state_ff <= ST_MODEW;
                        end else begin
                            state_ff <= ST_ADDR;
                        end
                    end
                end
                ST_MODEW: begin
                    if (tx_ready_in) begin
                        tx_valid_out <= 1'b0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_ADDR: begin
                    // Skip the tag word at the data area start
                    data_address_reg_ff <=
                        data_area_pointer_reg_ff + 16'h0001; // [R4] [R5]
                    state_ff <= (word_count_reg_ff == RST_CNT)
                                ? ST_IDLE : ST_XFER; // [R11]
                end
                ST_XFER: begin
                    if (ctrl_ff[CTRL_MASTER_BIT]) begin
                        mem_req_out.req <= 1'b1;
                        mem_req_out.wr <= 1'b0;
                        mem_req_out.addr <= data_address_reg_ff;
                        state_ff <= ST_WAIT;
                    end else if (rx_valid_in) begin
                        mem_req_out.req <= 1'b1;
                        mem_req_out.wr <= 1'b1;
                        mem_req_out.addr <= data_address_reg_ff;
                        mem_req_out.wdata <= rx_word_in;
                        state_ff <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tx_valid_out) begin
                        if (tx_ready_in) begin
                            tx_valid_out <= 1'b0;
                            state_ff <= (word_count_reg_ff == RST_CNT)
                                        ? ST_IDLE : ST_XFER; // [R11]
                        end
                    end else if (mem_ack_in) begin
                        mem_req_out.req <= 1'b0;
                        data_address_reg_ff <=
                            data_address_reg_ff + 16'h0001; // [R6]
                        word_count_reg_ff <=
                            word_count_reg_ff - 6'h01; // [R8]
                        if (!mem_req_out.wr) begin
                            tx_valid_out <= 1'b1;
                            tx_word_out <= mem_rdata_in;
                        end else begin
                            state_ff <= (word_count_reg_ff == 6'h01)
                                        ? ST_IDLE : ST_XFER; // [R11]
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Events for the status flags
    assign word_evt = state_ff == ST_WAIT && !tx_valid_out && mem_ack_in;
    assign done_evt = (state_ff == ST_ADDR && word_count_reg_ff == RST_CNT)
        || (word_evt && word_count_reg_ff == 6'h01);
    assign mode_evt = state_ff == ST_MODEW && tx_ready_in;

    // ==================================================
    // Interrupt status, write one to clear, set wins
    always_comb begin
        isr_set = RST_WORD;
        isr_set[ISR_PCI_BIT] =
            instruction_word_one_reg_ff[IW1_PCI_BIT]; // [R9]
        isr_set[ISR_DONE_BIT] = done_evt;
        isr_set[ISR_MODE_BIT] = mode_evt;
    end

    // Status register, event set beats software clear
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            interrupt_status_reg_ff <= RST_WORD;
        end else if (wr_acc && paddr_in == OFS_ISR) begin
            interrupt_status_reg_ff <=
                (interrupt_status_reg_ff & ~pwdata_in) | isr_set;
        end else begin
            interrupt_status_reg_ff <= interrupt_status_reg_ff | isr_set;
        end
    end

    // ==================================================
    // Priority scan from the rightmost field
    logic [LEVEL_W-1:0] nxt_level;
    logic [ISR_FIELDS*ISR_FIELD_W-1:0] pend;
    assign pend = interrupt_status_reg_ff & imask_ff;
    always_comb begin
        nxt_level = LEVEL_NONE;
        for (int i = ISR_FIELDS - 1; i >= 0; i--) begin
            if (pend[i*ISR_FIELD_W +: ISR_FIELD_W] != 4'h0) begin
                nxt_level = LEVEL_W'(i); // [R10]
            end
        end
    end

    // Registered interrupt outputs
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_out <= LEVEL_NONE;
            irq_out <= 1'b0;
        end else begin
            level_out <= nxt_level; // [R10]
            irq_out <= |pend;
        end
    end

    // ==================================================
    // Checks
    start_addr_a: assert property ( // [R5]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_ADDR |=> data_address_reg_ff
            == $past(data_area_pointer_reg_ff) + 16'h0001)
        else $error("data address not pointer plus one");
    addr_step_a: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rstn_in)
        word_evt |=> data_address_reg_ff
            == $past(data_address_reg_ff) + 16'h0001)
        else $error("data address did not step");
    count_step_a: assert property ( // [R8]
        @(posedge clk_in) disable iff (!rstn_in)
        word_evt |=> word_count_reg_ff
            == $past(word_count_reg_ff) - 6'h01)
        else $error("word count did not drop");
    count_load_a: assert property ( // [R7]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_IDLE && start_pls |=>
            word_count_reg_ff == $past(cmd_count_ff))
        else $error("word count not loaded");
    mode_word_a: assert property ( // [R1]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_MODEW |-> tx_valid_out
            && tx_word_out == mode_data_reg_ff)
        else $error("mode data word not sent");
    pci_set_a: assert property ( // [R9]
        @(posedge clk_in) disable iff (!rstn_in)
        instruction_word_one_reg_ff[IW1_PCI_BIT]
            |=> interrupt_status_reg_ff[ISR_PCI_BIT])
        else $error("program interrupt flag not set");
    zero_stop_a: assert property ( // [R11]
        @(posedge clk_in) disable iff (!rstn_in)
        word_count_reg_ff == RST_CNT && state_ff != ST_WAIT
            |-> !(state_ff == ST_XFER))
        else $error("transfer past zero count");
    remote_mode_a: assert property ( // [R3]
        @(posedge clk_in) disable iff (!rstn_in)
        !ctrl_ff[CTRL_MASTER_BIT] |-> state_ff != ST_MODEW)
        else $error("mode data used in remote mode");
    level_scan_a: assert property ( // [R10]
        @(posedge clk_in) disable iff (!rstn_in)
        pend[3:0] != 4'h0 |=> level_out == 4'h0)
        else $error("rightmost field not chosen");
    // Start decisions taken from the word being written
    mode_path_a: assert property ( // [R1]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_IDLE && start_pls && pwdata_in[CTRL_MASTER_BIT]
            && pwdata_in[CTRL_MODECMD_BIT] |=> state_ff == ST_MODEW)
        else $error("mode command did not send mode data");
    remote_path_a: assert property ( // [R3]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_IDLE && start_pls && !pwdata_in[CTRL_MASTER_BIT]
            |=> state_ff == ST_ADDR && !tx_valid_out)
        else $error("remote start did not go to data phase");
    // Memory and word handshakes hold until answered; requests carry the data address and the received word
    mem_hold_a: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rstn_in)
        mem_req_out.req && !mem_ack_in |=> mem_req_out.req
            && $stable(mem_req_out.addr) && $stable(mem_req_out.wr))
        else $error("memory request dropped early");
    req_addr_a: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rstn_in)
        $rose(mem_req_out.req) |-> mem_req_out.addr == data_address_reg_ff)
        else $error("memory request not at data address");
    tx_hold_a: assert property ( // [R1]
        @(posedge clk_in) disable iff (!rstn_in)
        tx_valid_out && !tx_ready_in
            |=> tx_valid_out && $stable(tx_word_out))
        else $error("bus word dropped before accepted");
    remote_write_a: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_XFER && !ctrl_ff[CTRL_MASTER_BIT] && rx_valid_in
            |=> mem_req_out.req && mem_req_out.wr
            && mem_req_out.wdata == $past(rx_word_in))
        else $error("received word not stored");
    // Data phase ends at zero count
    zero_idle_a: assert property ( // [R11]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_ADDR && word_count_reg_ff == RST_CNT
            |=> state_ff == ST_IDLE && !mem_req_out.req)
        else $error("empty transfer touched memory");
    last_write_a: assert property ( // [R11]
        @(posedge clk_in) disable iff (!rstn_in)
        word_evt && mem_req_out.wr && word_count_reg_ff == 6'h01
            |=> state_ff == ST_IDLE)
        else $error("remote transfer ran past last word");
    last_read_a: assert property ( // [R11]
        @(posedge clk_in) disable iff (!rstn_in)
        state_ff == ST_WAIT && tx_valid_out && tx_ready_in
            && word_count_reg_ff == RST_CNT |=> state_ff == ST_IDLE)
        else $error("master transfer ran past last word");
    // Interrupt output follows the masked status
    irq_set_a: assert property ( // [R10]
        @(posedge clk_in) disable iff (!rstn_in)
        pend != '0 |=> irq_out)
        else $error("pending field gave no interrupt");
    irq_none_a: assert property ( // [R10]
        @(posedge clk_in) disable iff (!rstn_in)
        pend == '0 |=> !irq_out && level_out == LEVEL_NONE)
        else $error("interrupt without pending field");
endmodule
`default_nettype wire

// ### tb/bit_far_side.sv
`default_nettype none
module bit_far_side
    import bit_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            rstn_in,
    input  wire logic            slow_in,
    input  wire logic            rx_en_in,
    input  wire bit_mem_req_type mem_req_in,
    output logic                 mem_ack_out,
    output logic          [15:0] mem_rdata_out,
    input  wire logic            tx_valid_in,
    output logic                 tx_ready_out,
    output logic                 rx_valid_out,
    output logic          [15:0] rx_word_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0]  mem_wait_ff;
    logic [1:0]  tx_wait_ff;
    logic [15:0] rx_seq_ff;
    logic [1:0]  delay;

    // ==========================================
    // Memory and bus word partner
    assign delay = slow_in ? 2'h3 : 2'h0;

    // Memory answers after the delay; data line toggles when idle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_ack_out   <= 1'b0;
            mem_wait_ff   <= 2'h0;
            mem_rdata_out <= 16'h0000;
        end else if (mem_req_in.req && !mem_ack_out
                     && mem_wait_ff == delay) begin
            mem_ack_out   <= 1'b1;
            mem_wait_ff   <= 2'h0;
            mem_rdata_out <= mem_req_in.addr ^ 16'h5A00;
        end else begin
            mem_ack_out   <= 1'b0;
            mem_wait_ff   <= mem_req_in.req ? mem_wait_ff + 2'h1 : 2'h0;
            mem_rdata_out <= ~mem_rdata_out;
        end
    end

    // Word sink accepts after the same delay
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_ready_out <= 1'b0;
            tx_wait_ff   <= 2'h0;
        end else if (tx_valid_in && !tx_ready_out
                     && tx_wait_ff == delay) begin
            tx_ready_out <= 1'b1;
            tx_wait_ff   <= 2'h0;
        end else begin
            tx_ready_out <= 1'b0;
            tx_wait_ff   <= tx_valid_in ? tx_wait_ff + 2'h1 : 2'h0;
        end
    end

    // Received words advance once each stored word is acknowledged
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_valid_out <= 1'b0;
            rx_seq_ff    <= 16'h0000;
        end else begin
            rx_valid_out <= rx_en_in;
            if (!rx_en_in) begin
                rx_seq_ff <= 16'h0000;
            end else if (mem_ack_out && mem_req_in.wr) begin
                rx_seq_ff <= rx_seq_ff + 16'h0001;
            end
        end
    end

    // Idle word line shows the inverse pattern
    assign rx_word_out = rx_valid_out ? 16'hC000 + rx_seq_ff
                                      : ~(16'hC000 + rx_seq_ff);
endmodule
`default_nettype wire

// ### tb/tb.sv
`default_nettype none
`define CHK(g, x) begin \
    check_count++; \
    if ((g) !== (x)) begin \
        err_total++; \
        $display("ERROR %0t got %0h want %0h", $time, g, x); \
    end \
end
module tb
    import bit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_in, rstn_in, psel, penable, pwrite;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, r;
    logic                 pready, pslverr, mem_ack, e, slow, rx_en;
    bit_mem_req_type      mem_req;
    logic [15:0]          mem_rdata, tx_word, rx_word;
    logic                 tx_valid, tx_ready, rx_valid, irq;
    logic [LEVEL_W-1:0]   level;
    int                   err_total, check_count;
    logic [32:0]          mq[$];
    logic [15:0]          tq[$];

    bit_bus_interface_unit DUT (.clk_in(clk_in), .rstn_in(rstn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .mem_req_out(mem_req), .mem_ack_in(mem_ack),
        .mem_rdata_in(mem_rdata), .tx_valid_out(tx_valid),
        .tx_word_out(tx_word), .tx_ready_in(tx_ready),
        .rx_valid_in(rx_valid), .rx_word_in(rx_word),
        .irq_out(irq), .level_out(level));

    bit_far_side far (.clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow),
        .rx_en_in(rx_en), .mem_req_in(mem_req), .mem_ack_out(mem_ack),
        .mem_rdata_out(mem_rdata), .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
        .rx_word_out(rx_word));

    // ==========================================
    // Clock, monitors and bus tasks
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Log completed memory accesses and sent words
    always @(posedge clk_in) begin
        if (mem_req.req === 1'b1 && mem_ack === 1'b1)
            mq.push_back({mem_req.wr, mem_req.addr,
                          mem_req.wr ? mem_req.wdata : mem_rdata});
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            tq.push_back(tx_word);
    end

    task automatic give_verdict();
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            give_verdict();
        end
    endtask

    // Start a transfer and poll busy under a bound
    task automatic xfer(input logic [31:0] c, input logic [15:0] p,
                        input logic [5:0] cnt);
        int n;
        mq.delete();
        tq.delete();
        apb(1'b1, OFS_PTR, {16'h0000, p});
        apb(1'b1, OFS_CMD, {26'h0, cnt});
        apb(1'b1, OFS_CTRL, c);
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            err_total++;
            give_verdict();
        end
    endtask

    task automatic chk_mem(input logic w, input logic [15:0] p, input int c);
        logic [15:0] a;
        `CHK(mq.size(), c)
        for (int k = 0; k < c; k++) begin
            a = p + 16'h0001 + k[15:0];
            `CHK(mq[k], {w, a, w ? 16'hC000 + k[15:0] : a ^ 16'h5A00})
            if (!w) `CHK(tq[k], a ^ 16'h5A00)
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {rstn_in, psel, penable, pwrite, slow, rx_en} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        err_total = 0;
        check_count = 0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        `CHK(level, LEVEL_NONE)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({e, r}, 33'h1_0000_0000)
        apb(1'b1, OFS_IMASK, 32'h0000_0007);
        slow <= 1'b1;
        xfer(32'h3, 16'h0100, 6'h03);
        chk_mem(1'b0, 16'h0100, 3);
        apb(1'b0, OFS_DADDR, 32'h0);
        `CHK(r, 32'h0000_0104)
        apb(1'b0, OFS_WCOUNT, 32'h0);
        `CHK(r, 32'h0000_0000)
        `CHK({irq, level}, 5'h10)
        apb(1'b1, OFS_ISR, 32'hFFFF_FFFF);
        repeat (2) @(posedge clk_in);
        `CHK({irq, level}, {1'b0, LEVEL_NONE})
        slow <= 1'b0;
        xfer(32'h3, 16'h0300, 6'h00);
        chk_mem(1'b0, 16'h0300, 0);
        apb(1'b0, OFS_DADDR, 32'h0);
        `CHK(r, 32'h0000_0301)
        apb(1'b1, OFS_MODEDAT, 32'h0000_BEEF);
        xfer(32'h7, 16'h0400, 6'h02);
        `CHK({tq.size(), tq[0], mq.size()}, {32'd1, 16'hBEEF, 32'd0})
        apb(1'b0, OFS_WCOUNT, 32'h0);
        `CHK(r, 32'h0000_0002)
        apb(1'b1, OFS_ISR, 32'hFFFF_FFFF);
        rx_en <= 1'b1;
        slow <= 1'b1;
        xfer(32'h6, 16'h0200, 6'h02);
        rx_en <= 1'b0;
        chk_mem(1'b1, 16'h0200, 2);
        `CHK(tq.size(), 0)
        apb(1'b0, OFS_WCOUNT, 32'h0);
        `CHK(r, 32'h0000_0000)
        apb(1'b1, OFS_ISR, 32'hFFFF_FFFF);
        apb(1'b1, OFS_IMASK, 32'h0000_0000);
        apb(1'b1, OFS_IWORD1, 32'h0000_8000);
        apb(1'b0, OFS_ISR, 32'h0);
        `CHK(r[ISR_PCI_BIT], 1'b1)
        `CHK({irq, level}, {1'b0, LEVEL_NONE})
        apb(1'b1, OFS_IMASK, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        `CHK({irq, level}, 5'h10)
        apb(1'b1, OFS_IWORD1, 32'h0000_0000);
        apb(1'b1, OFS_ISR, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        `CHK({irq, level}, {1'b0, LEVEL_NONE})
        give_verdict();
    end
endmodule
`default_nettype wire
